/* File: src/tfs_cfg.svh */
// Purpose: constants for the timer-three flag skip decoder
// Assumes: included by bare name
// Notes: definitions only
`ifndef TFS_CFG_SVH
`define TFS_CFG_SVH
// selection bit position inside interrupt control register two
`define TFS_SEL_BIT 0
`define TFS_ICR2_W 4
`define TFS_ICR2_RST 4'h0
`define TFS_PC_W 13
`define TFS_PC_RST 13'h0000
`endif

/* File: src/tfs_exec.sv */
// Purpose: executes the timer-three flag skip and the set-reference-enable instruction
// Assumes: one instruction per mclk cycle, presented with instr_valid
// Notes: the timer raises its request flag via t3_set; skip suppresses next instruction
`timescale 1ns/100ps
`include "tfs_cfg.svh"

// Operation
// - the test selection bit is bit 0 of interrupt control register two.
// - with selection 0 and flag 1, the skip instruction clears the flag and skips the next one.
// - with selection 0 and flag 0, the skip instruction does not skip.
// - with selection 1, the skip instruction is a no-operation and leaves the flag alone.
// - the set-reference-enable instruction writes 1 into the reference enable flag.
module tfs_exec
   import tfs_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // instruction stream
   input wire logic instr_valid,
   input wire tfs_op_t instr_op,
   // interrupt control register two write port
   input wire logic icr2_we,
   input wire logic [`TFS_ICR2_W-1:0] icr2_wdata,
   // timer three request event
   input wire logic t3_set,
   // state
   output logic timer_three_request_flag,
   output logic high_order_ref_enable_flag,
   output logic [`TFS_ICR2_W-1:0] interrupt_control_reg_two,
   output logic [`TFS_PC_W-1:0] pc,
   output logic skip_pending,
   output logic instr_suppressed
);
   logic [`TFS_ICR2_W-1:0] icr2_q;
   logic t3f_q;
   logic ref_q;
   logic [`TFS_PC_W-1:0] pc_q;
   tfs_state_t state_q;
   tfs_state_t state_d;

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   // an instruction only acts when it is valid and not the victim of a skip
   function automatic logic op_live(input logic valid, input tfs_state_t st,
                                    input tfs_op_t op, input tfs_op_t want);
      op_live = valid && (st == TFS_ST_RUN) && (op == want);
   endfunction

   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire timer_three_test_select_bit = icr2_q[`TFS_SEL_BIT];
   wire live = instr_valid && (state_q == TFS_ST_RUN);
   wire skip_if_timer_three_flag = op_live(instr_valid, state_q, instr_op, TFS_OP_SKIP_T3);
   wire testing = skip_if_timer_three_flag && !timer_three_test_select_bit;
   wire take_skip = testing && t3f_q;
   wire set_ref = op_live(instr_valid, state_q, instr_op, TFS_OP_SET_REF);
   // live is kept for the checks below, which speak of executing instructions
   wire live_other = live && (instr_op == TFS_OP_OTHER);

   always_comb begin
      case (state_q)
         TFS_ST_RUN: state_d = take_skip ? TFS_ST_SKIP : TFS_ST_RUN;
         TFS_ST_SKIP: state_d = instr_valid ? TFS_ST_RUN : TFS_ST_SKIP;
         default: state_d = TFS_ST_RUN;
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= TFS_ST_RUN;
         pc_q <= `TFS_PC_RST;
      end else begin
         state_q <= state_d;
         if (instr_valid) begin
            pc_q <= pc_q + `TFS_PC_W'(1);
         end
      end
   end

   // timer event wins over the clear in the same cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         t3f_q <= 1'b0;
      end else if (t3_set) begin
         t3f_q <= 1'b1;
      end else if (take_skip) begin
         t3f_q <= 1'b0;
      end
   end

   // a skipped write to the control register is dropped too
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         icr2_q <= `TFS_ICR2_RST;
         ref_q <= 1'b0;
      end else begin
         if (icr2_we && !(state_q == TFS_ST_SKIP)) begin
            icr2_q <= icr2_wdata;
         end
         if (set_ref) begin
            ref_q <= 1'b1;
         end
      end
   end

   assign timer_three_request_flag = t3f_q;
   assign high_order_ref_enable_flag = ref_q;
   assign interrupt_control_reg_two = icr2_q;
   assign pc = pc_q;
   assign skip_pending = (state_q == TFS_ST_SKIP);
   assign instr_suppressed = instr_valid && (state_q == TFS_ST_SKIP);

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // the steps of a skip: the test is taken, then the next valid slot is swallowed
   sequence skip_taken_s;
      instr_valid && !skip_pending && instr_op == TFS_OP_SKIP_T3 && !icr2_q[0] && t3f_q;
   endsequence

   sequence no_timer_event_s;
      !t3_set;
   endsequence

   sequence victim_slot_s;
      skip_pending && instr_valid;
   endsequence

   sequence idle_slot_s;
      !instr_valid;
   endsequence

   skip_clear_a: assert property (@(posedge mclk) disable iff (rst)
      (skip_taken_s and no_timer_event_s) |=> !timer_three_request_flag && skip_pending)
      else $error("taken skip did not clear flag or arm skip");

   // the timer event in the same slot keeps the flag, but the skip is still taken
   skip_race_a: assert property (@(posedge mclk) disable iff (rst)
      (skip_taken_s and (t3_set)) |=> timer_three_request_flag && skip_pending)
      else $error("skip lost when timer event coincided");

   noskip_zero_a: assert property (@(posedge mclk) disable iff (rst)
      instr_valid && !skip_pending && instr_op == TFS_OP_SKIP_T3 && !icr2_q[0] && !t3f_q
      |=> !skip_pending)
      else $error("skip taken with flag clear");
   nop_select_a: assert property (@(posedge mclk) disable iff (rst)
      instr_valid && !skip_pending && instr_op == TFS_OP_SKIP_T3 && icr2_q[0]
      |=> !skip_pending && timer_three_request_flag == $past(t3f_q || t3_set))
      else $error("skip acted while selection bit set");
   sel_bit_a: assert property (@(posedge mclk) disable iff (rst)
      instr_valid && !skip_pending && instr_op == TFS_OP_SKIP_T3 && icr2_q[0]
      |-> !take_skip)
      else $error("selection bit not taken from bit 0");
   ref_set_a: assert property (@(posedge mclk) disable iff (rst)
      instr_valid && !skip_pending && instr_op == TFS_OP_SET_REF |=> high_order_ref_enable_flag)
      else $error("reference enable flag not set");
   skip_suppress_a: assert property (@(posedge mclk) disable iff (rst)
      skip_pending && instr_valid && instr_op == TFS_OP_SET_REF && !ref_q
      |=> !high_order_ref_enable_flag)
      else $error("skipped instruction had effect");
   skip_pc_a: assert property (@(posedge mclk) disable iff (rst)
      skip_pending && instr_valid |=> pc == $past(pc) + 13'h0001 && !skip_pending)
      else $error("skip did not advance pc or end");
   event_wins_a: assert property (@(posedge mclk) disable iff (rst)
      t3_set |=> timer_three_request_flag)
      else $error("timer event lost");

   // without a set or a taken skip the flag must not move
   flag_hold_a: assert property (@(posedge mclk) disable iff (rst)
      !t3_set && !take_skip |=> timer_three_request_flag == $past(t3f_q))
      else $error("timer flag changed without cause");

   // a skip waits through idle slots for its victim
   skip_wait_a: assert property (@(posedge mclk) disable iff (rst)
      skip_pending && idle_slot_s |=> skip_pending && pc == $past(pc))
      else $error("pending skip lost in idle slot");

   pc_idle_a: assert property (@(posedge mclk) disable iff (rst)
      idle_slot_s |=> pc == $past(pc))
      else $error("pc moved without an instruction");

   // a register write carried by a swallowed instruction must be dropped
   icr2_drop_a: assert property (@(posedge mclk) disable iff (rst)
      victim_slot_s and (icr2_we) |=> interrupt_control_reg_two == $past(icr2_q))
      else $error("skipped instruction wrote control register");

   icr2_write_a: assert property (@(posedge mclk) disable iff (rst)
      icr2_we && !skip_pending |=> interrupt_control_reg_two == $past(icr2_wdata))
      else $error("control register write lost");

   // once set only reset clears the reference enable flag
   ref_sticky_a: assert property (@(posedge mclk) disable iff (rst)
      ref_q |=> high_order_ref_enable_flag)
      else $error("reference enable flag dropped");

   // other instructions must neither arm a skip nor touch the timer flag
   other_quiet_a: assert property (@(posedge mclk) disable iff (rst)
      live_other && !t3_set |=> !skip_pending && timer_three_request_flag == $past(t3f_q))
      else $error("unrelated instruction had skip effect");

   suppress_out_a: assert property (@(posedge mclk) disable iff (rst)
      victim_slot_s |-> instr_suppressed)
      else $error("victim slot not flagged suppressed");
endmodule // tfs_exec

/* File: src/tfs_pkg.sv */
// Purpose: types for the timer-three flag skip decoder
// Assumes: nothing
// Notes: operation codes are decoded outside this block
package tfs_pkg;
   typedef enum logic [2:0] {
      TFS_OP_OTHER = 3'h1,
      TFS_OP_SKIP_T3 = 3'h2,
      TFS_OP_SET_REF = 3'h4
   } tfs_op_t;
   typedef enum logic [1:0] {
      TFS_ST_RUN = 2'h1,
      TFS_ST_SKIP = 2'h2
   } tfs_state_t;
endpackage

/* File: tb/tb.sv */
// Purpose: random self-checking bench for the timer-three flag skip decoder
// Assumes: outputs settle before the falling edge
// Notes: icr2 writes ride only with non-skip instructions, so their ordering is unambiguous
`timescale 1ns/100ps
module tb;
   import tfs_pkg::*;
   logic mclk = 0, rst = 1, instr_valid = 0, icr2_we = 0, t3_set = 0;
   tfs_op_t instr_op = TFS_OP_OTHER;
   logic [3:0] icr2_wdata = 4'h0;
   logic flag_o, ref_o, skip_o, supp_o;
   logic [3:0] icr2_o;
   logic [12:0] pc_o;
   logic [31:0] lfsr = 32'h5918;
   int failures = 0, checks_done = 0, cycles = 0;
   int m_flag, m_ref, m_icr2, m_pc, m_skip;
   always #50 mclk = ~mclk;
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   tfs_exec dut (.mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op),
      .icr2_we(icr2_we), .icr2_wdata(icr2_wdata), .t3_set(t3_set),
      .timer_three_request_flag(flag_o), .high_order_ref_enable_flag(ref_o),
      .interrupt_control_reg_two(icr2_o), .pc(pc_o), .skip_pending(skip_o),
      .instr_suppressed(supp_o));
   // ----------------------------------------
   // checking and closing
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // model update and random stimulus
   // ----------------------------------------
   always @(posedge mclk) begin
      logic sup, clr;
      tfs_op_t op;
      sup = instr_valid && m_skip[0];
      clr = instr_valid && !sup && instr_op == TFS_OP_SKIP_T3 && !m_icr2[0] && m_flag[0];
      if (++cycles > 3000) begin
         failures++;
         end_of_test;
      end
      if (rst) begin
         {m_flag, m_ref, m_icr2, m_pc, m_skip} = '0;
      end else begin
         if (instr_valid) m_pc = (m_pc + 1) % 8192;
         if (icr2_we && !sup) m_icr2 = icr2_wdata;
         if (instr_valid && !sup && instr_op == TFS_OP_SET_REF) m_ref = 1;
         if (instr_valid) m_skip = clr;
         m_flag = t3_set ? 1 : (clr ? 0 : m_flag);
         lfsr = lfsr_next(lfsr);
         op = lfsr[3:2] == 2'h0 ? TFS_OP_OTHER : lfsr[3:2] == 2'h2 ? TFS_OP_SET_REF : TFS_OP_SKIP_T3;
         instr_valid <= lfsr[0] | lfsr[1];
         instr_op <= op;
         icr2_we <= (lfsr[0] | lfsr[1]) && op != TFS_OP_SKIP_T3 && lfsr[4];
         icr2_wdata <= lfsr[9:6];
         t3_set <= lfsr[10] & lfsr[11];
      end
   end
   always @(negedge mclk) begin
      check(16'(flag_o), 16'(m_flag));
      check(16'(skip_o), 16'(m_skip));
      check(16'(icr2_o), 16'(m_icr2));
      check(16'(ref_o), 16'(m_ref));
      check(16'(pc_o), 16'(m_pc));
      check(16'(supp_o), 16'(instr_valid && m_skip[0]));
   end
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 0;
      repeat (2000) @(posedge mclk);
      end_of_test;
   end
endmodule // tb
